/* File: emcr_top.sv */
`timescale 1ns/1ps
module emcr_top
  import emcr_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              manual_rst,
  input  wire logic              bus_busy,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [3:0]             col_bits_r,
  output logic [4:0]             bank_lsb_r,
  output logic                   bank_two_r,
  output logic                   edo_sample_r,
  output logic                   refresh_pulse_r,
  output logic                   self_refresh_r,
  output logic [5:0]             card_extra_wait_r,
  output logic [6:0]             card_total_wait_r,
  output logic [3:0]             card_strobe_delay_r,
  output logic [3:0]             card_addr_hold_r
);
  logic [1:0]           rst_sync_r;
  logic                 rstn_s;
  logic                 aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic [ADDR_W-1:0]    waddr_r, waddr_nxt;
  logic [31:0]          wdata_r, wdata_nxt;
  logic [3:0]           wstrb_r, wstrb_nxt;
  logic                 awready_nxt, wready_nxt, arready_nxt;
  logic                 bvalid_nxt, rvalid_nxt;
  logic [1:0]           bresp_nxt, rresp_nxt;
  logic [31:0]          rdata_nxt, wmask;
  logic                 wr_fire;
  logic [MEM_CFG_W-1:0] mem_cfg_r, mem_cfg_nxt;
  logic [15:0]          card_r, card_nxt;
  logic [4:0]           aux_r, aux_nxt;
  logic [7:0]           rconst_r, rconst_nxt, rcnt_r, rcnt_nxt;
  logic                 cmf_r, cmf_nxt, pend_r, pend_nxt;
  logic                 pulse_nxt, self_nxt, match;
  logic [2:0]           mux_sel, dly_code, hld_code;
  logic                 rf_on, rf_kind, tsel;
  logic [3:0]           col_nxt, dly_w, hld_w;
  logic [4:0]           bank_nxt;
  logic                 two_nxt;
  logic [5:0]           xw_nxt;

  // Async assert, synchronous release
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rstn_s  = rst_sync_r[1];
  assign mux_sel = mem_cfg_r[MC_MUX_LO +: 3];
  assign rf_on   = mem_cfg_r[MC_ON];
  assign rf_kind = mem_cfg_r[MC_KIND];
  assign tsel    = aux_r[AUX_TSEL];
  assign match   = (rcnt_r == rconst_r);
  assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
  assign wmask   = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}},
                    {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

  // Bus slave: address and data taken in either order
  always_comb
  begin
    aw_got_nxt = aw_got_r;
    w_got_nxt  = w_got_r;
    waddr_nxt  = waddr_r;
    wdata_nxt  = wdata_r;
    wstrb_nxt  = wstrb_r;
    bvalid_nxt = s_axi_bvalid;
    bresp_nxt  = s_axi_bresp;
    rvalid_nxt = s_axi_rvalid;
    rresp_nxt  = s_axi_rresp;
    rdata_nxt  = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_got_nxt = 1'b1;
      waddr_nxt  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_got_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready)
      bvalid_nxt = 1'b0;
    if (wr_fire)
    begin
      aw_got_nxt = 1'b0;
      w_got_nxt  = 1'b0;
      bvalid_nxt = 1'b1;
      case (waddr_r)
        OFF_MEM_CFG, OFF_CARD, OFF_CARD_AUX,
        OFF_REF_CONST, OFF_STATUS:  bresp_nxt = RESP_OK;
        default:                    bresp_nxt = RESP_SLVERR;
      endcase
    end
    if (s_axi_rvalid && s_axi_rready)
      rvalid_nxt = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OK;
      case (s_axi_araddr)
        OFF_MEM_CFG:    rdata_nxt = {23'h0, mem_cfg_r};
        OFF_CARD:       rdata_nxt = {16'h0, card_r};
        OFF_CARD_AUX:   rdata_nxt = {27'h0, aux_r};
        OFF_REF_CONST:  rdata_nxt = {24'h0, rconst_r};
        OFF_STATUS:     rdata_nxt = {21'h0, rcnt_r, pend_r,
                                     self_refresh_r, cmf_r};
        default:
        begin
          rdata_nxt = 32'h0;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
    awready_nxt = !aw_got_nxt && !bvalid_nxt;
    wready_nxt  = !w_got_nxt && !bvalid_nxt;
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge clk or negedge rstn_s)
  begin
    if (!rstn_s)
    begin
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      waddr_r       <= '0;
      wdata_r       <= 32'h0;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OK;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= RESP_OK;
      s_axi_rdata   <= 32'h0;
    end
    else
    begin
      aw_got_r      <= aw_got_nxt;
      w_got_r       <= w_got_nxt;
      waddr_r       <= waddr_nxt;
      wdata_r       <= wdata_nxt;
      wstrb_r       <= wstrb_nxt;
      s_axi_awready <= awready_nxt;
      s_axi_wready  <= wready_nxt;
      s_axi_arready <= arready_nxt;
      s_axi_bvalid  <= bvalid_nxt;
      s_axi_bresp   <= bresp_nxt;
      s_axi_rvalid  <= rvalid_nxt;
      s_axi_rresp   <= rresp_nxt;
      s_axi_rdata   <= rdata_nxt;
    end
  end

  // Registers and refresh engine
  always_comb
  begin
    mem_cfg_nxt = mem_cfg_r;
    card_nxt    = card_r;
    aux_nxt     = aux_r;
    rconst_nxt  = rconst_r;
    cmf_nxt     = cmf_r;
    if (wr_fire)
    begin
      case (waddr_r)
        OFF_MEM_CFG:    mem_cfg_nxt = MEM_CFG_W'((32'(mem_cfg_r) & ~wmask)
                                      | (wdata_r & wmask));
        OFF_CARD:       card_nxt    = 16'((32'(card_r) & ~wmask)
                                      | (wdata_r & wmask));
        OFF_CARD_AUX:   aux_nxt     = 5'((32'(aux_r) & ~wmask)
                                      | (wdata_r & wmask));
        OFF_REF_CONST:  rconst_nxt  = 8'((32'(rconst_r) & ~wmask)
                                      | (wdata_r & wmask));
        OFF_STATUS:
          if (wstrb_r[0] && !wdata_r[ST_CMF])
            cmf_nxt = 1'b0;
        default:        cmf_nxt = cmf_r;
      endcase
    end
    // Timer runs whatever the refresh setting
    rcnt_nxt = match ? 8'h0 : rcnt_r + 8'h1; // R7
    if (match)
      cmf_nxt = 1'b1; // Set beats a same-cycle clear
    pend_nxt  = pend_r;
    pulse_nxt = 1'b0;
    self_nxt  = self_refresh_r;
    if (match && rf_on && !rf_kind)
      pend_nxt = 1'b1; // R8
    if (rf_on && rf_kind && !bus_busy)
      self_nxt = 1'b1; // R10
    else if (!(rf_on && rf_kind))
      self_nxt = 1'b0;
    if (!rf_on || self_refresh_r)
      pend_nxt = 1'b0; // R6 R11
    else if (pend_r && !bus_busy && !rf_kind)
    begin
      pulse_nxt = 1'b1; // R9
      pend_nxt  = match; // Fresh match outlives the drain
    end
    // Manual reset spares the card register
    if (manual_rst)
    begin
      mem_cfg_nxt = MEM_CFG_RST;
      aux_nxt     = AUX_RST;
      rconst_nxt  = REF_CONST_RST;
      rcnt_nxt    = 8'h0;
      cmf_nxt     = 1'b0;
      pend_nxt    = 1'b0;
      pulse_nxt   = 1'b0;
      self_nxt    = 1'b0;
      card_nxt    = card_r; // R14
    end
  end

  always_ff @(posedge clk or negedge rstn_s)
  begin
    if (!rstn_s)
    begin
      mem_cfg_r       <= MEM_CFG_RST;
      card_r          <= CARD_RST; // R14
      aux_r           <= AUX_RST;
      rconst_r        <= REF_CONST_RST;
      rcnt_r          <= 8'h0;
      cmf_r           <= 1'b0;
      pend_r          <= 1'b0;
      refresh_pulse_r <= 1'b0;
      self_refresh_r  <= 1'b0;
    end
    else
    begin
      mem_cfg_r       <= mem_cfg_nxt;
      card_r          <= card_nxt;
      aux_r           <= aux_nxt;
      rconst_r        <= rconst_nxt;
      rcnt_r          <= rcnt_nxt;
      cmf_r           <= cmf_nxt;
      pend_r          <= pend_nxt;
      refresh_pulse_r <= pulse_nxt;
      self_refresh_r  <= self_nxt;
    end
  end

  // Address mux and card timing decode
  assign dly_code = tsel ? card_r[A6_DLY_LO +: 3] : card_r[A5_DLY_LO +: 3];
  assign hld_code = tsel ? card_r[A6_HLD_LO +: 3] : card_r[A5_HLD_LO +: 3];

  emcr_wait_dec u_dly_dec (
    .code  (dly_code),
    .waits (dly_w)
  );

  emcr_wait_dec u_hld_dec (
    .code  (hld_code),
    .waits (hld_w)
  );

  always_comb
  begin
    // Prohibited codes fall back to the reset width
    col_nxt = (mux_sel <= 3'h4) ? COL_BITS_RST + 4'(mux_sel)
                                : COL_BITS_RST; // R1 R19
    two_nxt = 1'b0;
    case (mux_sel) // R3
      3'h0: bank_nxt = 5'h16;
      3'h1: bank_nxt = 5'h17;
      3'h2:
      begin
        bank_nxt = 5'h17;
        two_nxt  = 1'b1;
      end
      3'h3:
      begin
        bank_nxt = 5'h18;
        two_nxt  = 1'b1;
      end
      3'h4:
      begin
        bank_nxt = 5'h16; // R4
        two_nxt  = 1'b1;
      end
      3'h5:    bank_nxt = 5'h17; // R5
      3'h7:    bank_nxt = 5'h15;
      default: bank_nxt = 5'h00; // R19
    endcase
    // Extension bit only shifts codes 0 and 1
    if (mux_sel <= 3'h1 && mem_cfg_r[MC_EXT])
      bank_nxt = bank_nxt - 5'h1; // R3
    // 32-bit bus moves every bank bit down by one, except for code 6
    if (mem_cfg_r[MC_BUS32] && bank_nxt != 5'h00)
      bank_nxt = bank_nxt - 5'h1; // R4 R5
    xw_nxt = tsel ? XW_TAB[6*card_r[A6_XW_LO +: 2] +: 6]  // R16
                  : XW_TAB[6*card_r[A5_XW_LO +: 2] +: 6]; // R15
  end

  always_ff @(posedge clk or negedge rstn_s)
  begin
    if (!rstn_s)
    begin
      col_bits_r          <= COL_BITS_RST;
      bank_lsb_r          <= 5'h00;
      bank_two_r          <= 1'b0;
      edo_sample_r        <= 1'b0;
      card_extra_wait_r   <= 6'h00;
      card_total_wait_r   <= 7'h00;
      card_strobe_delay_r <= 4'h0;
      card_addr_hold_r    <= 4'h0;
    end
    else
    begin
      col_bits_r          <= col_nxt;
      bank_lsb_r          <= bank_nxt;
      bank_two_r          <= two_nxt;
      // Sampling shift is meaningless for other memory types
      edo_sample_r        <= mem_cfg_r[MC_EDO] && !mem_cfg_r[MC_SDRAM]; // R12
      card_extra_wait_r   <= xw_nxt;
      card_total_wait_r   <= 7'(xw_nxt) + 7'(aux_r[AUX_BASE_LO +: 4]); // R13
      card_strobe_delay_r <= dly_w; // R18
      card_addr_hold_r    <= hld_w;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn_s);

  sequence s_req_held;
    pend_r && bus_busy && rf_on && !rf_kind && !self_refresh_r &&
      !manual_rst;
  endsequence
  sequence s_bus_free;
    !bus_busy && rf_on && !rf_kind && !self_refresh_r && !manual_rst;
  endsequence

  property p_col_bits;
    (mux_sel == 3'h3 && !manual_rst) |=> col_bits_r == 4'hb;
  endproperty
  a_col_bits: assert property (p_col_bits) // R1
    else $error("column width wrong");
  property p_bank_c4;
    (mux_sel == 3'h4 && mem_cfg_r[MC_BUS32]) |=>
      bank_lsb_r == 5'h15 && bank_two_r;
  endproperty
  a_bank_c4: assert property (p_bank_c4) // R4
    else $error("bank bits for code 4 wrong");
  property p_bank_c5;
    (mux_sel == 3'h5 && mem_cfg_r[MC_BUS32]) |=>
      bank_lsb_r == 5'h16 && !bank_two_r;
  endproperty
  a_bank_c5: assert property (p_bank_c5) // R5
    else $error("bank bit for code 5 wrong");
  property p_bank_ext;
    (mux_sel == 3'h0 && mem_cfg_r[MC_EXT] && mem_cfg_r[MC_BUS32]) |=>
      bank_lsb_r == 5'h14;
  endproperty
  a_bank_ext: assert property (p_bank_ext) // R3
    else $error("extension shift wrong");
  property p_no_refresh_off;
    !rf_on |=> !refresh_pulse_r;
  endproperty
  a_no_refresh_off: assert property (p_no_refresh_off) // R6
    else $error("refresh while disabled");
  property p_timer_runs;
    (!rf_on && !match && !manual_rst) |=> rcnt_r == $past(rcnt_r) + 8'h1;
  endproperty
  a_timer_runs: assert property (p_timer_runs) // R7
    else $error("timer stalled");
  property p_req_held;
    s_req_held |=> pend_r && !refresh_pulse_r;
  endproperty
  a_req_held: assert property (p_req_held) // R9
    else $error("request lost in bus cycle");
  property p_req_fire;
    pend_r ##0 s_bus_free |=> refresh_pulse_r && pend_r == $past(match);
  endproperty
  a_req_fire: assert property (p_req_fire) // R9
    else $error("held request not run");
  property p_self_entry;
    $rose(self_refresh_r) |-> $past(!bus_busy && rf_on && rf_kind);
  endproperty
  a_self_entry: assert property (p_self_entry) // R10
    else $error("self-refresh entered early");
  property p_self_quiet;
    self_refresh_r |=> !refresh_pulse_r ##1 !refresh_pulse_r || !self_nxt;
  endproperty
  a_self_quiet: assert property (p_self_quiet) // R11
    else $error("refresh during self-refresh");
  property p_edo;
    mem_cfg_r[MC_SDRAM] |=> !edo_sample_r;
  endproperty
  a_edo: assert property (p_edo) // R12
    else $error("sampling shift on other memory");
  property p_card_keep;
    (manual_rst && !wr_fire) |=> card_r == $past(card_r);
  endproperty
  a_card_keep: assert property (p_card_keep) // R14
    else $error("card timing lost on manual reset");
  property p_xw_a5;
    (!tsel && card_r[A5_XW_LO +: 2] == 2'h3) |=> card_extra_wait_r == 6'h32;
  endproperty
  a_xw_a5: assert property (p_xw_a5) // R15
    else $error("area 5 extra wait wrong");
  property p_xw_a6;
    (tsel && card_r[A6_XW_LO +: 2] == 2'h1) |=> card_extra_wait_r == 6'h0f;
  endproperty
  a_xw_a6: assert property (p_xw_a6) // R16
    else $error("area 6 extra wait wrong");
  property p_dly_a5;
    (!tsel && card_r[A5_DLY_LO +: 3] == 3'h5) |=> card_strobe_delay_r == 4'h9;
  endproperty
  a_dly_a5: assert property (p_dly_a5) // R17
    else $error("strobe delay wrong");
endmodule // emcr_top

/* File: emcr_pkg.sv */
// Contract
// R1 - DRAM column width from mux code: 0..4 give 8..12 bits, reset 8.
// R2 - Software keeps the mux extension bit zero for conventional DRAM.
// R3 - SDRAM bank bits follow mux code, extension bit and bus width.
// R4 - SDRAM code 4 on 32-bit bus uses address bits 22:21 as bank.
// R5 - SDRAM code 5 on 32-bit bus uses address bit 22 as bank.
// R6 - Refresh cycles only while refresh is on; off after reset.
// R7 - Refresh interval timer keeps running while refresh is off.
// R8 - Refresh on, kind zero: periodic refresh timed by counter and constant.
// R9 - Refresh request during a bus cycle waits until that cycle ends.
// R10 - Refresh on, kind one: finish bus cycle, then enter self-refresh.
// R11 - While in self-refresh every refresh request is dropped.
// R12 - Extended data out select only moves the DRAM read sampling point.
// R13 - Card strobe timing from card register; strobe width from wait control.
// R14 - Card timing register cleared only by power-on reset.
// R15 - Timing select zero: area 5 extra waits 0, 15, 30 or 50 added.
// R16 - Timing select one: area 6 extra waits added, same encoding.
// R17 - Address to strobe delay codes give 0,1,2,3,6,9,12,15 waits.
// R18 - Area 5 delay field governs card access only with timing select zero.
// R19 - Prohibited encodings give a consistent but undefined result.
package emcr_pkg;
  localparam int unsigned ADDR_W        = 8;
  localparam logic [7:0]  OFF_MEM_CFG   = 8'h00;
  localparam logic [7:0]  OFF_CARD      = 8'h04;
  localparam logic [7:0]  OFF_CARD_AUX  = 8'h08;
  localparam logic [7:0]  OFF_REF_CONST = 8'h0c;
  localparam logic [7:0]  OFF_STATUS    = 8'h10;
  localparam logic [1:0]  RESP_OK       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  // Memory configuration fields
  localparam int unsigned MC_EDO        = 0;
  localparam int unsigned MC_KIND       = 1;
  localparam int unsigned MC_ON         = 2;
  localparam int unsigned MC_MUX_LO     = 3;
  localparam int unsigned MC_EXT        = 6;
  localparam int unsigned MC_BUS32      = 7;
  localparam int unsigned MC_SDRAM      = 8;
  localparam int unsigned MEM_CFG_W     = 9;
  localparam logic [8:0]  MEM_CFG_RST   = 9'h000;
  // Card strobe timing fields
  localparam logic [15:0] CARD_RST      = 16'h0000;
  localparam int unsigned A5_XW_LO      = 14;
  localparam int unsigned A6_XW_LO      = 12;
  localparam int unsigned A5_DLY_LO     = 9;
  localparam int unsigned A6_DLY_LO     = 6;
  localparam int unsigned A5_HLD_LO     = 3;
  localparam int unsigned A6_HLD_LO     = 0;
  // Card auxiliary fields
  localparam int unsigned AUX_TSEL      = 0;
  localparam int unsigned AUX_BASE_LO   = 1;
  localparam logic [4:0]  AUX_RST       = 5'h00;
  // Refresh, status and decode constants
  localparam logic [7:0]  REF_CONST_RST = 8'hff;
  localparam int unsigned ST_CMF        = 0;
  localparam int unsigned ST_SELF       = 1;
  localparam int unsigned ST_PEND       = 2;
  localparam logic [3:0]  COL_BITS_RST  = 4'h8;
  localparam logic [23:0] XW_TAB        = {6'h32, 6'h1e, 6'h0f, 6'h00};
  localparam logic [31:0] DLY_TAB       = 32'hfc963210;
endpackage

/* File: emcr_wait_dec.sv */
`timescale 1ns/1ps
module emcr_wait_dec
  import emcr_pkg::*;
#(
  parameter int unsigned CODE_W = 3,
  parameter int unsigned OUT_W  = 4,
  parameter logic [31:0] TAB    = DLY_TAB
)(
  input  wire logic [CODE_W-1:0] code,
  output logic      [OUT_W-1:0]  waits
);
  always_comb
  begin
    waits = TAB[code*OUT_W +: OUT_W]; // R17
  end
endmodule // emcr_wait_dec

/* File: emcr_mem_model.sv */
`timescale 1ns/1ps
module emcr_mem_model
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        start,
  input  wire logic [7:0]  len,
  input  wire logic        refresh_pulse,
  output logic             bus_busy,
  output logic [15:0]      n_refresh_r
);
  logic [7:0]  left_r;
  logic [7:0]  left_nxt;
  logic [15:0] n_refresh_nxt;

  // Bus cycle of commanded length, so refresh must wait behind it
  always_comb
  begin
    left_nxt = left_r;
    if (start)
      left_nxt = len;
    else if (left_r != 8'h00)
      left_nxt = left_r - 8'h01;
    n_refresh_nxt = n_refresh_r + {15'h0000, refresh_pulse};
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      left_r      <= 8'h00;
      n_refresh_r <= 16'h0000;
    end
    else
    begin
      left_r      <= left_nxt;
      n_refresh_r <= n_refresh_nxt;
    end
  end

  assign bus_busy = (left_r != 8'h00);
endmodule // emcr_mem_model

/* File: emcr_top_test.sv */
`timescale 1ns/1ps
module emcr_top_test
  import emcr_pkg::*;
;
  logic        clk, rstn, manual_rst, bus_busy, bus_start;
  logic [7:0]  bus_len, s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, col_bits_r, card_strobe_delay_r, card_addr_hold_r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, bank_two_r, edo_sample_r;
  logic        refresh_pulse_r, self_refresh_r;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [4:0]  bank_lsb_r;
  logic [5:0]  card_extra_wait_r;
  logic [6:0]  card_total_wait_r;
  logic [15:0] n_refresh_r;
  int          errors, n_compared;
  logic [31:0] dtab [8] = '{0, 1, 2, 3, 6, 9, 12, 15};
  logic [31:0] xtab [4] = '{0, 15, 30, 50};
  logic [2:0]  bc [9] = '{0, 0, 1, 1, 2, 3, 4, 5, 7};
  logic        be [9] = '{0, 1, 0, 1, 0, 0, 0, 0, 0};
  logic [4:0]  bl [9] = '{22, 21, 23, 22, 23, 24, 22, 23, 21};
  logic        bt [9] = '{0, 0, 0, 0, 1, 1, 1, 0, 0};

  emcr_top dut_u (.clk, .rstn, .manual_rst, .bus_busy, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .col_bits_r, .bank_lsb_r,
    .bank_two_r, .edo_sample_r, .refresh_pulse_r, .self_refresh_r,
    .card_extra_wait_r, .card_total_wait_r, .card_strobe_delay_r,
    .card_addr_hold_r);
  emcr_mem_model mem_u (.clk, .rstn, .start(bus_start), .len(bus_len),
    .refresh_pulse(refresh_pulse_r), .bus_busy, .n_refresh_r);

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic end_sim;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, e);
    n_compared++;
    if (s !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic [1:0] r;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    r = 2'h1;
    n = 0;
    while (n != 99)
    begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        n = 99;
      end
    end
    chk("bresp", 32'(r), 32'(a > OFF_STATUS ? RESP_SLVERR : RESP_OK));
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    logic [1:0] r;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    r = 2'h1;
    n = 0;
    while (n != 99)
    begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1)
      begin
        r = s_axi_rresp;
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        n = 99;
      end
    end
    chk("rresp", 32'(r), 32'(a > OFF_STATUS ? RESP_SLVERR : RESP_OK));
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk("rdata", d, e);
  endtask

  task automatic por;
    @(posedge clk);
    rstn <= 1'b0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  task automatic busy(input logic [7:0] n);
    @(posedge clk);
    bus_start <= 1'b1;
    bus_len <= n;
    @(posedge clk);
    bus_start <= 1'b0;
  endtask

  task automatic wait_idle;
    while (bus_busy === 1'b1)
      @(posedge clk);
  endtask

  task automatic t_init;
    chk("col", 32'(col_bits_r), 32'h8);
    rdc(OFF_MEM_CFG, 32'h0);
    rdc(OFF_CARD, 32'h0);
    rdc(OFF_CARD_AUX, 32'h0);
    rdc(OFF_REF_CONST, 32'hff);
    rdc(8'h20, 32'h0);
    wr(8'h20, 32'hffffffff);
    $display("test init done");
  endtask

  task automatic t_mux;
    for (int m = 0; m < 5; m++)
    begin
      wr(OFF_MEM_CFG, 32'(m) << 3);
      repeat (2) @(posedge clk);
      chk("col", 32'(col_bits_r), 32'(8 + m));
    end
    for (int i = 0; i < 9; i++)
      for (int b = 0; b < 2; b++)
      begin
        wr(OFF_MEM_CFG, 32'({1'b1, b[0], be[i], bc[i], 3'h0}));
        repeat (2) @(posedge clk);
        chk("bank", 32'(bank_lsb_r), 32'(bl[i] - b));
        chk("bank2", 32'(bank_two_r), 32'(bt[i]));
      end
    wr(OFF_MEM_CFG, 32'h001);
    repeat (2) @(posedge clk);
    chk("edo", 32'(edo_sample_r), 32'h1);
    wr(OFF_MEM_CFG, 32'h101);
    repeat (2) @(posedge clk);
    chk("edo", 32'(edo_sample_r), 32'h0);
    $display("test mux done");
  endtask

  task automatic t_card;
    logic [2:0] c, v, s;
    logic [1:0] x;
    for (int t = 0; t < 2; t++)
    begin
      wr(OFF_CARD_AUX, 32'(t) | 32'h0a); // Base waits of 5
      for (int i = 0; i < 8; i++)
      begin
        c = 3'(i);
        v = 3'(7 - i);
        wr(OFF_CARD, 32'({c[1:0], v[1:0], c, v, c, v}));
        repeat (2) @(posedge clk);
        s = t ? v : c;
        x = t ? v[1:0] : c[1:0];
        chk("xw", 32'(card_extra_wait_r), xtab[x]);
        chk("tw", 32'(card_total_wait_r), xtab[x] + 32'd5);
        chk("dly", 32'(card_strobe_delay_r), dtab[s]);
        chk("hold", 32'(card_addr_hold_r), dtab[s]);
      end
    end
    $display("test card done");
  endtask

  task automatic t_refresh;
    logic [31:0] d;
    logic [15:0] n0;
    wr(OFF_REF_CONST, 32'h0f);
    wr(OFF_MEM_CFG, 32'h100);
    repeat (300) @(posedge clk);
    n0 = n_refresh_r;
    wr(OFF_STATUS, 32'h0);
    repeat (20) @(posedge clk);
    rd(OFF_STATUS, d);
    chk("cmf", 32'(d[ST_CMF]), 32'h1);
    chk("nref", 32'(n_refresh_r), 32'(n0));
    wr(OFF_MEM_CFG, 32'h104);
    repeat (20) @(posedge clk);
    n0 = n_refresh_r;
    repeat (160) @(posedge clk);
    chk("nref", 32'(n_refresh_r - n0), 32'd10);
    busy(8'd40);
    repeat (2) @(posedge clk);
    n0 = n_refresh_r;
    wait_idle;
    chk("nref", 32'(n_refresh_r), 32'(n0));
    repeat (4) @(posedge clk);
    chk("late", 32'(n_refresh_r > n0), 32'h1);
    $display("test refresh done");
  endtask

  task automatic t_self;
    logic [15:0] n0;
    busy(8'd30);
    wr(OFF_MEM_CFG, 32'h106);
    @(posedge clk);
    chk("self", 32'(self_refresh_r), 32'h0);
    wait_idle;
    repeat (3) @(posedge clk);
    chk("self", 32'(self_refresh_r), 32'h1);
    n0 = n_refresh_r;
    repeat (64) @(posedge clk);
    chk("nref", 32'(n_refresh_r), 32'(n0));
    wr(OFF_MEM_CFG, 32'h100);
    repeat (3) @(posedge clk);
    chk("self", 32'(self_refresh_r), 32'h0);
    $display("test self done");
  endtask

  task automatic t_reset;
    wr(OFF_CARD, 32'hffffffff);
    s_axi_wstrb <= 4'h1;
    wr(OFF_CARD, 32'h0);
    s_axi_wstrb <= 4'hf;
    @(posedge clk);
    manual_rst <= 1'b1;
    @(posedge clk);
    manual_rst <= 1'b0;
    rdc(OFF_CARD, 32'h0000ff00);
    rdc(OFF_MEM_CFG, 32'h0);
    rdc(OFF_REF_CONST, 32'hff);
    por;
    rdc(OFF_CARD, 32'h0);
    $display("test reset done");
  endtask

  initial
  begin
    rstn = 1'b0;
    manual_rst = 1'b0;
    bus_start = 1'b0;
    bus_len = 8'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    errors = 0;
    n_compared = 0;
    por;
    t_init;
    t_mux;
    t_card;
    t_refresh;
    t_self;
    t_reset;
    end_sim;
  end

  // Whole run is about a thousand cycles; this bound only catches hangs
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    end_sim;
  end
endmodule // emcr_top_test
